// ==== rtl/tmwr_pkg.sv ====
package tmwr_pkg;

  localparam int AXI_AW = 8;
  localparam int TOT_W = 16;
  localparam int SYM_W = 8;
  localparam int MS_W = 10;
  localparam int SB_DEPTH = 256;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG1 = 8'h04;
  localparam logic [7:0] ADDR_CFG3 = 8'h08;
  localparam logic [7:0] ADDR_FRAME = 8'h0c;
  localparam logic [7:0] ADDR_TOTAL0 = 8'h10;
  localparam logic [7:0] ADDR_TOTAL1 = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  localparam int CTRL_START_BIT = 0;
  localparam int CFG1_REL_LSB = 0;
  localparam int REL_W = 7;
  localparam int CFG1_PRO_LSB = 16;
  localparam int PRO_W = 6;
  localparam int CFG3_POL_BIT = 0;
  localparam int CFG3_NOMAX_BIT = 1;
  localparam int CFG3_PRED_BIT = 2;
  localparam int CFG3_SHARED_BIT = 3;
  localparam int FRAME_W = 15;
  localparam int STAT_LAST_BIT = 0;
  localparam int STAT_READY_BIT = 1;
  localparam int STAT_POS_LSB = 8;

  localparam logic [6:0] REL_FIELD_RST = 7'h7f;
  localparam logic [5:0] PRO_RST = 6'h18;
  localparam logic [14:0] FRAME_RST = 15'h0028;

  localparam logic [7:0] REL_MIN = 8'h28;
  localparam logic [7:0] REL_MAX = 8'h80;
  localparam logic [5:0] PRO_MIN = 6'h04;
  localparam logic [5:0] PRO_MAX = 6'h30;
  localparam logic [5:0] PRO_RED_MAX = 6'h10;
  localparam logic [5:0] PRO_SP_ALIGN = 6'h08;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // correction by |a-b|, index 7 first
  localparam logic [7:0][2:0] MS_LUT = {3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3};

  typedef struct packed {
    logic hard;
    logic x_sign;
    logic x_zero;
    logic p0_sign;
    logic p0_zero;
    logic p1_sign;
    logic p1_zero;
  } tmwr_entry_s;

  typedef enum logic [1:0] {
    DR_IDLE = 2'b00,
    DR_RUN = 2'b01,
    DR_TAIL = 2'b11
  } tmwr_drain_e;

endpackage

// ==== rtl/tmwr_reenc_if.sv ====
`timescale 1ns/1ps
interface tmwr_reenc_if #(
  parameter int TOT_W = tmwr_pkg::TOT_W
) ();
  logic wr_valid;
  logic wr_ready;
  tmwr_pkg::tmwr_entry_s wr_entry;
  logic wr_map;
  logic wr_last;
  logic clear;
  logic [TOT_W-1:0] total0;
  logic [TOT_W-1:0] total1;

  modport feeder (output wr_valid, wr_entry, wr_map, wr_last, clear, input wr_ready, total0, total1);
  modport counter (input wr_valid, wr_entry, wr_map, wr_last, clear, output wr_ready, total0, total1);
endinterface

// ==== rtl/tmwr_reencoder.sv ====
`timescale 1ns/1ps
module tmwr_reencoder #(
  parameter int DEPTH = tmwr_pkg::SB_DEPTH,
  parameter int TOT_W = tmwr_pkg::TOT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  tmwr_reenc_if.counter rif
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic wbank;
    logic [AW:0] widx;
    logic pending;
    logic [AW:0] pend_cnt;
    logic pend_map;
    tmwr_pkg::tmwr_drain_e dst;
    logic rbank;
    logic [AW:0] ridx;
    logic [AW:0] rcnt;
    logic rmap;
    logic rd_v;
    logic [2:0] enc0;
    logic [2:0] enc1;
    logic [TOT_W-1:0] total0;
    logic [TOT_W-1:0] total1;
    logic ready;
  } tmwr_reenc_s;

  tmwr_reenc_s st;
  tmwr_reenc_s next_st;
  tmwr_pkg::tmwr_entry_s mem [2*DEPTH];
  tmwr_pkg::tmwr_entry_s rd_q;
  logic wr_fire;
  logic wr_end;
  logic [AW:0] waddr;
  logic [AW:0] raddr;
  logic d;
  logic f;
  logic ep0;
  logic ep1;
  logic mx;
  logic m0;
  logic m1;
  logic [2:0] es;
  logic [1:0] inc;

  always_comb begin
    next_st = st;
    wr_fire = rif.wr_valid && st.ready;
    waddr = {st.wbank, st.widx[AW-1:0]};
    raddr = {st.rbank, st.ridx[AW-1:0]};
    // R5: a full bank closes the sub-block
    wr_end = wr_fire && (rif.wr_last || st.widx == (AW+1)'(DEPTH-1));
    // R16: rsc encoder, one step per entry
    d = rd_q.hard;
    es = st.rmap ? st.enc1 : st.enc0;
    f = d ^ es[1] ^ es[2];
    ep0 = f ^ es[0] ^ es[2];
    ep1 = f ^ es[0] ^ es[1] ^ es[2];
    // R19: second pass ignores systematic
    mx = !st.rmap && !rd_q.x_zero && (d != rd_q.x_sign);
    // R17: zero symbols carry no sign
    m0 = !rd_q.p0_zero && (ep0 != rd_q.p0_sign);
    m1 = !rd_q.p1_zero && (ep1 != rd_q.p1_sign);
    inc = {1'b0, mx} + {1'b0, m0} + {1'b0, m1};
    next_st.rd_v = 1'b0;
    if (st.rd_v) begin
      // R18: separate totals per pass
      if (st.rmap) begin
        next_st.enc1 = {es[1:0], f};
        next_st.total1 = st.total1 + TOT_W'(inc);
      end else begin
        next_st.enc0 = {es[1:0], f};
        next_st.total0 = st.total0 + TOT_W'(inc);
      end
    end
    if (wr_fire) begin
      next_st.widx = st.widx + 1'b1;
    end
    // R13: other bank still draining, hold this one
    if (wr_end && st.dst != tmwr_pkg::DR_IDLE) begin
      next_st.pending = 1'b1;
      next_st.pend_cnt = st.widx + 1'b1;
      next_st.pend_map = rif.wr_map;
    end
    case (st.dst)
      tmwr_pkg::DR_IDLE: begin
        // R13: swap banks, drain the filled one
        if (st.pending) begin
          next_st.rbank = st.wbank;
          next_st.rcnt = st.pend_cnt;
          next_st.rmap = st.pend_map;
          next_st.ridx = '0;
          next_st.dst = tmwr_pkg::DR_RUN;
          next_st.wbank = ~st.wbank;
          next_st.widx = '0;
          next_st.pending = 1'b0;
        end else if (wr_end) begin
          next_st.rbank = st.wbank;
          next_st.rcnt = st.widx + 1'b1;
          next_st.rmap = rif.wr_map;
          next_st.ridx = '0;
          next_st.dst = tmwr_pkg::DR_RUN;
          next_st.wbank = ~st.wbank;
          next_st.widx = '0;
        end
      end
      tmwr_pkg::DR_RUN: begin
        next_st.rd_v = 1'b1;
        next_st.ridx = st.ridx + 1'b1;
        if (st.ridx + 1'b1 == st.rcnt) begin
          next_st.dst = tmwr_pkg::DR_TAIL;
        end
      end
      tmwr_pkg::DR_TAIL: begin
        next_st.dst = tmwr_pkg::DR_IDLE;
      end
      default: begin
        next_st.dst = tmwr_pkg::DR_IDLE;
      end
    endcase
    next_st.ready = !next_st.pending;
    // R22: new frame wipes totals and encoders
    if (rif.clear) begin
      next_st = '0;
      next_st.ready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // R13: two banks of sub-block entries
  always_ff @(posedge aclk) begin
    if (wr_fire) begin
      mem[waddr] <= rif.wr_entry;
    end
    rd_q <= mem[raddr];
  end

  assign rif.wr_ready = st.ready;
  assign rif.total0 = st.total0;
  assign rif.total1 = st.total1;
endmodule // tmwr_reencoder

// ==== rtl/tmwr_top.sv ====
// Contract
// R1: reliability per window may be anything from 40 to 128 symbols.
// R2: prolog length programmable 4 to 48; software picks by puncturing.
// R3: with prolog reduction, software keeps prolog between 4 and 16.
// R4: in shared mode, software keeps prolog a multiple of 8.
// R5: sub-block at most 256 symbols, one or two windows of at most 128.
// R6: last window may be short; beta starts from tails, no beta prolog.
// R7: software sizes reliability so the last window keeps a positive remainder.
// R8: software writes reliability minus one into config word one.
// R9: bad sizing never raises an error; decoding simply runs on.
// R10: input is always a rate 1/5 de-punctured stream.
// R11: polarity bit negates each soft symbol internally, no extra cycles; code negates only x, p0, p1, a priori and extrinsic pass unchanged.
// R12: recursion uses max-star or plain max, chosen per frame.
// R13: up to 256 entries per sub-block in a double-buffered memory.
// R14: entry holds sign and zero flag of x, p0, p1, plus hard bit.
// R15: hard bit is sign of systematic plus a priori plus extrinsic.
// R16: hard bits re-encoded into systematic and two parity streams.
// R17: sign mismatches counted, skipping positions flagged as zero.
// R18: first and second pass mismatch totals kept apart, both output.
// R19: first pass compares x, p0, p1; second pass only p0, p1.
// R20: re-encoder fed directly from the hard-decision stream.
// R21: max-star control bit 0 adds table correction, 1 gives plain max.
// R22: both totals cleared at each frame start before any counting.
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module tmwr_top #(
  parameter int SYM_W = tmwr_pkg::SYM_W,
  parameter int MS_W = tmwr_pkg::MS_W,
  parameter int TOT_W = tmwr_pkg::TOT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tmwr_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tmwr_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sym_valid,
  output logic sym_ready,
  input wire logic [SYM_W-1:0] sym_x,
  input wire logic [SYM_W-1:0] sym_p0,
  input wire logic [SYM_W-1:0] sym_p1,
  input wire logic [SYM_W-1:0] sym_apriori,
  input wire logic [SYM_W-1:0] sym_extr,
  input wire logic sym_map,
  output logic [7:0] win_rel_len,
  output logic [5:0] win_prolog_len,
  output logic win_beta_from_tail,
  output logic map_plain_max,
  input wire logic ms_valid,
  input wire logic [MS_W-1:0] ms_a,
  input wire logic [MS_W-1:0] ms_b,
  output logic ms_out_valid,
  output logic [MS_W:0] ms_out,
  output logic [TOT_W-1:0] first_pass_mismatch_total,
  output logic [TOT_W-1:0] second_pass_mismatch_total
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [6:0] rel_field;
    logic [5:0] prolog;
    logic pol_inv;
    logic no_max_star;
    logic prolog_reduce;
    logic shared_mode;
    logic [14:0] frame_len;
    logic clear;
    logic [7:0] win_pos;
    logic [1:0] win_in_sb;
    logic [14:0] consumed;
    logic [14:0] win_start;
    logic win_last;
    logic [7:0] rel_len;
    logic ms_v;
    logic [MS_W:0] ms_out;
  } tmwr_top_s;

  tmwr_top_s st;
  tmwr_top_s next_st;
  tmwr_reenc_if #(.TOT_W(TOT_W)) rif ();

  logic start_frame;
  logic [31:0] rd;
  logic [1:0] rresp_v;
  logic sym_fire;
  logic [7:0] rel;
  logic frame_end;
  logic win_end;
  logic sb_end;
  logic [1:0] sw_per_sb;
  logic [SYM_W-1:0] x_c;
  logic [SYM_W-1:0] p0_c;
  logic [SYM_W-1:0] p1_c;
  logic [SYM_W+1:0] hsum;
  tmwr_pkg::tmwr_entry_s entry;
  logic [MS_W:0] diff;
  logic a_ge;
  logic [MS_W-1:0] mx;
  logic [MS_W:0] absd;
  logic [2:0] corr;

  // saturate so the most negative code still flips sign
  function automatic logic [SYM_W-1:0] tmwr_pol(input logic [SYM_W-1:0] v, input logic inv);
    logic [SYM_W-1:0] r;
    r = v;
    if (inv) begin
      if (v == {1'b1, {(SYM_W-1){1'b0}}}) begin
        r = {1'b0, {(SYM_W-1){1'b1}}};
      end else begin
        r = -v;
      end
    end
    return r;
  endfunction

  always_comb begin
    next_st = st;
    next_st.clear = 1'b0;
    start_frame = 1'b0;
    rd = 32'h0000_0000;
    rresp_v = tmwr_pkg::RESP_OKAY;

    if (s_axi_awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = tmwr_pkg::RESP_OKAY;
      case (st.aw_addr)
        tmwr_pkg::ADDR_CTRL: begin
          start_frame = st.w_strb[0] && st.w_data[tmwr_pkg::CTRL_START_BIT];
        end
        tmwr_pkg::ADDR_CFG1: begin
          // R8: field holds reliability minus one
          if (st.w_strb[0]) begin
            next_st.rel_field = st.w_data[tmwr_pkg::CFG1_REL_LSB +: tmwr_pkg::REL_W];
          end
          // R2: prolog length stored as written
          if (st.w_strb[2]) begin
            next_st.prolog = st.w_data[tmwr_pkg::CFG1_PRO_LSB +: tmwr_pkg::PRO_W];
          end
        end
        tmwr_pkg::ADDR_CFG3: begin
          if (st.w_strb[0]) begin
            next_st.pol_inv = st.w_data[tmwr_pkg::CFG3_POL_BIT];
            next_st.no_max_star = st.w_data[tmwr_pkg::CFG3_NOMAX_BIT];
            next_st.prolog_reduce = st.w_data[tmwr_pkg::CFG3_PRED_BIT];
            next_st.shared_mode = st.w_data[tmwr_pkg::CFG3_SHARED_BIT];
          end
        end
        tmwr_pkg::ADDR_FRAME: begin
          if (st.w_strb[0]) begin
            next_st.frame_len[7:0] = st.w_data[7:0];
          end
          if (st.w_strb[1]) begin
            next_st.frame_len[14:8] = st.w_data[14:8];
          end
        end
        tmwr_pkg::ADDR_TOTAL0, tmwr_pkg::ADDR_TOTAL1, tmwr_pkg::ADDR_STATUS: begin
        end
        default: begin
          next_st.bresp = tmwr_pkg::RESP_DECERR;
        end
      endcase
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready = !next_st.w_got && !next_st.bvalid;

    case (s_axi_araddr)
      tmwr_pkg::ADDR_CTRL: rd = 32'h0000_0000;
      tmwr_pkg::ADDR_CFG1: begin
        rd[tmwr_pkg::CFG1_REL_LSB +: tmwr_pkg::REL_W] = st.rel_field;
        rd[tmwr_pkg::CFG1_PRO_LSB +: tmwr_pkg::PRO_W] = st.prolog;
      end
      tmwr_pkg::ADDR_CFG3: begin
        rd[tmwr_pkg::CFG3_POL_BIT] = st.pol_inv;
        rd[tmwr_pkg::CFG3_NOMAX_BIT] = st.no_max_star;
        rd[tmwr_pkg::CFG3_PRED_BIT] = st.prolog_reduce;
        rd[tmwr_pkg::CFG3_SHARED_BIT] = st.shared_mode;
      end
      tmwr_pkg::ADDR_FRAME: rd[tmwr_pkg::FRAME_W-1:0] = st.frame_len;
      tmwr_pkg::ADDR_TOTAL0: rd[TOT_W-1:0] = rif.total0;
      tmwr_pkg::ADDR_TOTAL1: rd[TOT_W-1:0] = rif.total1;
      tmwr_pkg::ADDR_STATUS: begin
        rd[tmwr_pkg::STAT_LAST_BIT] = st.win_last;
        rd[tmwr_pkg::STAT_READY_BIT] = rif.wr_ready;
        rd[tmwr_pkg::STAT_POS_LSB +: 8] = st.win_pos;
      end
      default: rresp_v = tmwr_pkg::RESP_DECERR;
    endcase
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd;
      next_st.rresp = rresp_v;
    end
    next_st.arready = !next_st.rvalid;

    // R1: any reliability 1..128 is taken, 40..128 intended
    rel = {1'b0, st.rel_field} + 8'h01;
    next_st.rel_len = rel;
    // R20: symbols go straight into the re-encode memory
    sym_fire = sym_valid && rif.wr_ready;
    frame_end = (st.consumed + 15'h0001) == st.frame_len;
    win_end = ((st.win_pos + 8'h01) == rel) || frame_end;
    // R5: short frames need one window per sub-block
    sw_per_sb = (st.frame_len <= {7'h00, tmwr_pkg::REL_MAX}) ? 2'h1 : 2'h2;
    sb_end = frame_end || (win_end && (st.win_in_sb + 2'h1) == sw_per_sb);
    if (sym_fire) begin
      next_st.consumed = st.consumed + 15'h0001;
      next_st.win_pos = st.win_pos + 8'h01;
      if (win_end) begin
        next_st.win_pos = 8'h00;
        next_st.win_start = st.consumed + 15'h0001;
        next_st.win_in_sb = sb_end ? 2'h0 : st.win_in_sb + 2'h1;
      end
      if (frame_end) begin
        next_st.consumed = 15'h0000;
        next_st.win_start = 15'h0000;
      end
    end
    // R22: start pulse clears totals
    if (start_frame) begin
      next_st.clear = 1'b1;
      next_st.consumed = 15'h0000;
      next_st.win_pos = 8'h00;
      next_st.win_in_sb = 2'h0;
      next_st.win_start = 15'h0000;
    end
    // R6: remainder fits one window, beta from tails
    next_st.win_last = (next_st.frame_len - next_st.win_start) <= {7'h00, rel};
    // R9: out-of-range sizing is never flagged

    // R11: negate channel symbols when asked
    x_c = tmwr_pol(sym_x, st.pol_inv);
    p0_c = tmwr_pol(sym_p0, st.pol_inv);
    p1_c = tmwr_pol(sym_p1, st.pol_inv);
    // R15: hard bit from x plus a priori plus extrinsic
    hsum = {{2{x_c[SYM_W-1]}}, x_c} + {{2{sym_apriori[SYM_W-1]}}, sym_apriori} + {{2{sym_extr[SYM_W-1]}}, sym_extr};
    // R14: sign and zero flag per symbol
    entry.hard = hsum[SYM_W+1];
    entry.x_sign = x_c[SYM_W-1];
    entry.x_zero = (x_c == '0);
    entry.p0_sign = p0_c[SYM_W-1];
    entry.p0_zero = (p0_c == '0);
    entry.p1_sign = p1_c[SYM_W-1];
    entry.p1_zero = (p1_c == '0);

    // R12: max-star kernel, per-frame choice
    diff = {ms_a[MS_W-1], ms_a} - {ms_b[MS_W-1], ms_b};
    a_ge = !diff[MS_W];
    mx = a_ge ? ms_a : ms_b;
    absd = a_ge ? diff : -diff;
    // R21: control bit set drops the correction
    corr = (st.no_max_star || absd[MS_W:3] != '0) ? 3'h0 : tmwr_pkg::MS_LUT[absd[2:0]];
    next_st.ms_v = ms_valid;
    if (ms_valid) begin
      next_st.ms_out = {mx[MS_W-1], mx} + {{(MS_W-2){1'b0}}, corr};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.rel_field <= tmwr_pkg::REL_FIELD_RST;
      st.prolog <= tmwr_pkg::PRO_RST;
      st.frame_len <= tmwr_pkg::FRAME_RST;
      st.rel_len <= tmwr_pkg::REL_MAX;
    end else begin
      st <= next_st;
    end
  end

  // R10: three symbols per step of the rate 1/5 stream
  assign rif.wr_valid = sym_valid;
  assign rif.wr_entry = entry;
  assign rif.wr_map = sym_map;
  assign rif.wr_last = sb_end;
  assign rif.clear = st.clear;

  tmwr_reencoder #(.DEPTH(tmwr_pkg::SB_DEPTH), .TOT_W(TOT_W)) u_reenc (
    .aclk(aclk),
    .aresetn(aresetn),
    .rif(rif.counter)
  );

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign sym_ready = rif.wr_ready;
  assign win_rel_len = st.rel_len;
  assign win_prolog_len = st.prolog;
  assign win_beta_from_tail = st.win_last;
  assign map_plain_max = st.no_max_star;
  assign ms_out_valid = st.ms_v;
  assign ms_out = st.ms_out;
  assign first_pass_mismatch_total = rif.total0;
  assign second_pass_mismatch_total = rif.total1;
endmodule // tmwr_top

// ==== verif/tmwr_top_asserts.sv ====
`timescale 1ns/1ps
module tmwr_top_asserts #(
  parameter int MS_W = tmwr_pkg::MS_W,
  parameter int TOT_W = tmwr_pkg::TOT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic ms_valid,
  input wire logic [MS_W-1:0] ms_a,
  input wire logic [MS_W-1:0] ms_b,
  input wire logic ms_out_valid,
  input wire logic [MS_W:0] ms_out,
  input wire logic map_plain_max,
  input wire logic [7:0] win_rel_len,
  input wire logic [TOT_W-1:0] first_pass_mismatch_total,
  input wire logic [TOT_W-1:0] second_pass_mismatch_total
);
  logic signed [MS_W:0] mx;
  always_comb begin
    mx = ($signed(ms_a) > $signed(ms_b)) ? (MS_W+1)'($signed(ms_a)) : (MS_W+1)'($signed(ms_b));
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_ms_pulse: assert property (ms_valid |=> ms_out_valid ##1 (ms_out_valid == $past(ms_valid)))
    else $error("max result valid wrong");
  chk_ms_plain: assert property (ms_valid && map_plain_max |=> ms_out == $past(mx))
    else $error("plain max wrong");
  chk_ms_corr: assert property (ms_valid && !map_plain_max && ms_a == ms_b |=> (MS_W+1)'(ms_out - $past(mx)) == 3)
    else $error("max star correction wrong");
  chk_rel_range: assert property (win_rel_len >= 8'h01 && win_rel_len <= 8'h80)
    else $error("reliability out of range");
  chk_tot0_step: assert property ($changed(first_pass_mismatch_total) |->
    first_pass_mismatch_total == '0 ||
    TOT_W'(first_pass_mismatch_total - $past(first_pass_mismatch_total)) <= TOT_W'(3))
    else $error("first total jumped");
  chk_tot1_step: assert property ($changed(second_pass_mismatch_total) |->
    second_pass_mismatch_total == '0 ||
    TOT_W'(second_pass_mismatch_total - $past(second_pass_mismatch_total)) <= TOT_W'(2))
    else $error("second total jumped");
endmodule // tmwr_top_asserts
bind tmwr_top tmwr_top_asserts #(.MS_W(MS_W), .TOT_W(TOT_W)) u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .ms_valid, .ms_a, .ms_b,
  .ms_out_valid, .ms_out, .map_plain_max, .win_rel_len, .first_pass_mismatch_total, .second_pass_mismatch_total);

// ==== verif/tmwr_sym_source.sv ====
`timescale 1ns/1ps
module tmwr_sym_source (
  input wire logic aclk,
  input wire logic go,
  input wire logic map,
  input wire logic slow,
  input wire logic [7:0] count,
  input wire logic sym_ready,
  output logic sym_valid = 1'b0,
  output logic [7:0] sym_x = 8'h00,
  output logic [7:0] sym_p0 = 8'h00,
  output logic [7:0] sym_p1 = 8'h00,
  output logic [7:0] sym_apriori = 8'h00,
  output logic [7:0] sym_extr = 8'h00,
  output logic sym_map = 1'b0,
  output logic busy = 1'b0
);
  logic [7:0] idx = 8'h00;
  logic tog = 1'b0;
  always @(posedge aclk) begin
    tog <= ~tog;
    if (go && !busy) begin
      busy <= 1'b1;
      idx <= 8'h00;
    end else if (sym_valid && sym_ready) begin
      // released x, p0, p1 lines are inverted; a priori, extrinsic and map keep their values
      sym_valid <= 1'b0;
      sym_x <= ~sym_x;
      sym_p0 <= ~sym_p0;
      sym_p1 <= ~sym_p1;
      idx <= idx + 8'h01;
    end else if (busy && !sym_valid && idx == count) begin
      busy <= 1'b0;
    end else if (busy && !sym_valid && (!slow || tog)) begin
      sym_valid <= 1'b1;
      sym_x <= 8'(idx * 45 - 90);
      sym_p0 <= 8'(idx * 3 - 6);
      sym_p1 <= 8'(77 - idx * 11);
      sym_apriori <= 8'(idx * 20 - 70);
      sym_extr <= idx;
      sym_map <= map;
    end
  end
endmodule // tmwr_sym_source

// ==== verif/tmwr_top_test.sv ====
`timescale 1ns/1ps
module tmwr_top_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, sym_valid, sym_ready, sym_map, busy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] sym_x, sym_p0, sym_p1, sym_ap, sym_ex, rel;
  logic go = 1'b0, map = 1'b0, slow = 1'b0, pol = 1'b0, ms_valid = 1'b0;
  logic [9:0] ms_a = 10'h000, ms_b = 10'h000;
  logic ms_ov, tail, plain;
  logic [10:0] ms_out;
  logic [5:0] pro;
  logic [15:0] tot0, tot1;
  int failures = 0, checked = 0;
  int exp_e [2];
  logic [2:0] st [2];
  always #4 aclk = ~aclk;
  tmwr_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sym_valid(sym_valid), .sym_ready(sym_ready), .sym_x(sym_x),
    .sym_p0(sym_p0), .sym_p1(sym_p1), .sym_apriori(sym_ap), .sym_extr(sym_ex), .sym_map(sym_map),
    .win_rel_len(rel), .win_prolog_len(pro), .win_beta_from_tail(tail), .map_plain_max(plain),
    .ms_valid(ms_valid), .ms_a(ms_a), .ms_b(ms_b), .ms_out_valid(ms_ov), .ms_out(ms_out),
    .first_pass_mismatch_total(tot0), .second_pass_mismatch_total(tot1));
  tmwr_sym_source src (.aclk(aclk), .go(go), .map(map), .slow(slow), .count(8'h08), .sym_ready(sym_ready),
    .sym_valid(sym_valid), .sym_x(sym_x), .sym_p0(sym_p0), .sym_p1(sym_p1), .sym_apriori(sym_ap),
    .sym_extr(sym_ex), .sym_map(sym_map), .busy(busy));
  always @(posedge aclk) begin
    if (sym_valid && sym_ready) begin : mon
      logic [7:0] x, p, q;
      logic [9:0] s;
      logic [2:0] t;
      logic d, f;
      x = pol ? -sym_x : sym_x;
      p = pol ? -sym_p0 : sym_p0;
      q = pol ? -sym_p1 : sym_p1;
      s = {{2{x[7]}}, x} + {{2{sym_ap[7]}}, sym_ap} + {{2{sym_ex[7]}}, sym_ex};
      d = s[9];
      t = st[sym_map];
      f = d ^ t[1] ^ t[2];
      exp_e[sym_map] += int'(!sym_map && x != 0 && d != x[7]) + int'(p != 0 && (f ^ t[0] ^ t[2]) != p[7]);
      exp_e[sym_map] += int'(q != 0 && (f ^ t[0] ^ t[1] ^ t[2]) != q[7]);
      st[sym_map] = {t[1], t[0], f};
    end
  end
  task automatic results;
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(tmwr_pkg::ADDR_CFG1, d, r);
    chk(d, 32'h0018007f);
    rd(tmwr_pkg::ADDR_CFG3, d, r);
    chk(d, 32'h0);
    rd(tmwr_pkg::ADDR_FRAME, d, r);
    chk(d, 32'h28);
    rd(8'h1c, d, r);
    chk({30'h0, r}, {30'h0, tmwr_pkg::RESP_DECERR});
    wr(8'h1c, 32'hffff, r);
    chk({30'h0, r}, {30'h0, tmwr_pkg::RESP_DECERR});
    wr(tmwr_pkg::ADDR_TOTAL0, 32'h5, r);
    rd(tmwr_pkg::ADDR_TOTAL0, d, r);
    chk(d, 32'h0);
  endtask
  task automatic t_sizing;
    logic [31:0] d;
    logic [1:0] r;
    int rl [3] = '{40, 128, 10};
    int pl [3] = '{4, 48, 16};
    for (int i = 0; i < 3; i++) begin
      wr(tmwr_pkg::ADDR_CFG1, (32'(pl[i]) << 16) | 32'(rl[i] - 1), r);
      #1;
      chk({30'h0, r}, 32'h0);
      chk({24'h0, rel}, 32'(rl[i]));
      chk({26'h0, pro}, 32'(pl[i]));
    end
    wr(tmwr_pkg::ADDR_CFG3, 32'hc, r);
    rd(tmwr_pkg::ADDR_CFG3, d, r);
    chk(d, 32'hc);
  endtask
  task automatic t_maxstar;
    logic [1:0] r;
    for (int m = 0; m < 2; m++) begin
      wr(tmwr_pkg::ADDR_CFG3, 32'(m) << 1, r);
      chk({31'h0, plain}, 32'(m));
      for (int k = 0; k < 2; k++) begin
        @(posedge aclk);
        ms_a <= k ? 10'h004 : 10'h005;
        ms_b <= k ? 10'h004 : 10'h002;
        ms_valid <= 1'b1;
        @(posedge aclk);
        ms_valid <= 1'b0;
        #1;
        chk({31'h0, ms_ov}, 32'h1);
        chk({21'h0, ms_out}, m ? (k ? 32'h4 : 32'h5) : (k ? 32'h7 : 32'h6));
      end
    end
  endtask
  task automatic t_reenc(input logic p);
    logic [1:0] r;
    pol = p;
    wr(tmwr_pkg::ADDR_CFG3, {31'h0, p}, r);
    wr(tmwr_pkg::ADDR_FRAME, 32'h8, r);
    wr(tmwr_pkg::ADDR_CFG1, 32'h00180007, r);
    exp_e[0] = 0;
    exp_e[1] = 0;
    st[0] = 3'h0;
    st[1] = 3'h0;
    wr(tmwr_pkg::ADDR_CTRL, 32'h1, r);
    repeat (2) @(posedge aclk);
    #1;
    chk({16'h0, tot0}, 32'h0);
    chk({16'h0, tot1}, 32'h0);
    chk({31'h0, tail}, 32'h1);
    for (int m = 0; m < 2; m++) begin
      @(posedge aclk);
      map <= m[0];
      slow <= m[0];
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      do @(posedge aclk); while (busy);
    end
    repeat (30) @(posedge aclk);
    chk({16'h0, tot0}, 32'(exp_e[0]));
    chk({16'h0, tot1}, 32'(exp_e[1]));
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    results();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_sizing();
    t_maxstar();
    t_reenc(1'b0);
    t_reenc(1'b1);
    results();
  end
endmodule // tmwr_top_test
